// ==== verilog/wct_pkg.sv ====
package wct_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int DATA_W  = 32;
  localparam int ADDR_W  = 32;
  localparam int ID_W    = 4;
  localparam int USER_W  = 4;
  localparam int LINE_B  = 64;
  // ----------------------------------------
  // Tie-off defaults
  // ----------------------------------------
  localparam logic [1:0] BURST_INCR  = 2'h1;
  localparam logic [7:0] LEN_DEF     = 8'h00;
  localparam logic       LOCK_NORMAL = 1'h0;
  localparam logic [3:0] NIB_DEF     = 4'h0;
  localparam logic [2:0] SNOOP_DEF   = 3'h0;
  // ----------------------------------------
  // Write kind codes on the snoop field
  // ----------------------------------------
  localparam logic [2:0] SN_UNIQUE = 3'h0;
  localparam logic [2:0] SN_CLEAN  = 3'h2;
  localparam logic [2:0] SN_BACK   = 3'h3;
  localparam logic [2:0] SN_EVICT  = 3'h4;
  typedef enum logic [2:0] {
    WK_UNIQUE = 3'h0,
    WK_BACK   = 3'h1,
    WK_CLEAN  = 3'h2,
    WK_EVICT  = 3'h3,
    WK_OTHER  = 3'h4
  } wct_kind_t;
  // ----------------------------------------
  // Presence mask bit positions
  // ----------------------------------------
  localparam int PB_ID = 0, PB_REGION = 1, PB_LEN = 2, PB_SIZE = 3;
  localparam int PB_BURST = 4, PB_LOCK = 5, PB_CACHE = 6, PB_QOS = 7;
  localparam int PB_USER = 8, PB_SNOOP = 9, PB_STRB = 10;
  localparam int PB_STASH = 11, PB_TRACE = 12, PB_N = 13;
  // ----------------------------------------
  // Controller registers, byte offsets
  // ----------------------------------------
  localparam logic [4:0] REG_ADDR = 5'h00;
  localparam logic [4:0] REG_ATTR = 5'h04;
  localparam logic [4:0] REG_DATA = 5'h08;
  localparam logic [4:0] REG_STRB = 5'h0c;
  localparam logic [4:0] REG_CTRL = 5'h10;
  localparam logic [4:0] REG_STAT = 5'h14;
  localparam int AT_LEN = 0, AT_SIZE = 8, AT_BURST = 11;
  localparam int AT_SNOOP = 13, AT_ID = 16;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b11,
    ST_DONE = 2'b10
  } wct_st_t;
  // Size code of a full-width beat
  function automatic logic [2:0] wct_bus_size(input int dw);
    return 3'($clog2(dw / 8));
  endfunction
endpackage

// ==== verilog/wct_wr_if.sv ====
`timescale 1ns/1ns
interface wct_wr_if
  import wct_pkg::*;
();
  logic              aw_valid;
  logic              aw_ready;
  logic [ADDR_W-1:0] aw_addr;
  logic [ID_W-1:0]   aw_id;
  logic [3:0]        aw_region;
  logic [7:0]        aw_len;
  logic [2:0]        aw_size;
  logic [1:0]        aw_burst;
  logic              aw_lock;
  logic [3:0]        aw_cache;
  logic [2:0]        aw_prot;
  logic [3:0]        aw_qos;
  logic [USER_W-1:0] aw_user;
  logic [2:0]        aw_snoop;
  logic              aw_stash_en;
  logic              aw_trace;
  logic [PB_N-1:0]   present;
  logic              w_valid;
  logic              w_ready;
  logic [DATA_W-1:0] w_data;
  logic [DATA_W/8-1:0] w_strb;
  logic              w_last;
  modport mst (
    output aw_valid, aw_addr, aw_id, aw_region, aw_len, aw_size,
           aw_burst, aw_lock, aw_cache, aw_prot, aw_qos, aw_user,
           aw_snoop, aw_stash_en, aw_trace, present,
           w_valid, w_data, w_strb, w_last,
    input  aw_ready, w_ready
  );
  modport slv (
    input  aw_valid, aw_addr, aw_id, aw_region, aw_len, aw_size,
           aw_burst, aw_lock, aw_cache, aw_prot, aw_qos, aw_user,
           aw_snoop, aw_stash_en, aw_trace, present,
           w_valid, w_data, w_strb, w_last,
    output aw_ready, w_ready
  );
endinterface

// ==== verilog/wct_wr_slave.sv ====
// What this block does
// R1: Whole line, all strobes: full variant
// R2: Partial coverage: partial variant
// R3: Partial label may still carry full line
// R4: Evict exists only as full line
// R5: Back/clean fullness derived from strobes
// R6: Valid and ready always present
// R7: Missing optional driver gets default
// R8: Protection and last always driven
// R9: Conditional signal present when property set
// R10: Optional conditional only with property
// R11: Master-only signals absent on slave
// R12: Defaults: incr, one beat, ones, size
// R13: Zero ids, user, cache; normal lock
// R14: Generic kind covers both variants
// R15: Tie-offs are constant, combinational
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module wct_wr_slave
  import wct_pkg::*;
#(
  parameter int  LINE_BYTES = LINE_B,
  parameter bit  TRACE_PROP = 1'b0,
  parameter bit  STASH_PROP = 1'b0
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  wct_wr_if.slv                  bus,
  output logic                   out_aw_valid,
  output logic [ADDR_W-1:0]      out_addr,
  output logic [ID_W-1:0]        out_id,
  output logic [7:0]             out_len,
  output logic [2:0]             out_size,
  output logic [1:0]             out_burst,
  output logic                   out_lock,
  output logic [3:0]             out_cache,
  output logic [2:0]             out_prot,
  output logic [3:0]             out_qos,
  output logic [3:0]             out_region,
  output logic [USER_W-1:0]      out_user,
  output logic                   out_stash_en,
  output logic                   out_trace,
  output logic                   out_beat_valid,
  output logic [DATA_W-1:0]      out_data,
  output logic [DATA_W/8-1:0]    out_strb,
  output logic                   out_last,
  output logic                   out_done,
  output wct_kind_t              out_kind,
  output logic                   out_full,
  output logic                   out_evict_err
);
  localparam int SB = DATA_W / 8;
  localparam int LW = $clog2(LINE_BYTES);
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (LINE_BYTES < SB || LINE_BYTES % SB != 0) begin : g_chk
    $error("line size must be a multiple of the beat size");
  end
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    wct_st_t             st;
    logic                awr;
    logic                wr;
    logic                aw_v;
    logic [ADDR_W-1:0]   addr;
    logic [ID_W-1:0]     id;
    logic [7:0]          len;
    logic [2:0]          size;
    logic [1:0]          burst;
    logic                lock;
    logic [3:0]          cache;
    logic [2:0]          prot;
    logic [3:0]          qos;
    logic [3:0]          region;
    logic [USER_W-1:0]   user;
    logic [2:0]          snoop;
    logic                stash;
    logic                trace;
    logic [8:0]          beats;
    logic                ones;
    logic                bv;
    logic [DATA_W-1:0]   data;
    logic [SB-1:0]       strb;
    logic                last;
    logic                done;
    wct_kind_t           kind;
    logic                full;
    logic                everr;
  } wct_sl_t;
  wct_sl_t s, next_s;
  // Tied-off view of the address channel and the write strobes
  logic [ID_W-1:0]   t_id;
  logic [7:0]        t_len;
  logic [2:0]        t_size;
  logic [1:0]        t_burst;
  logic              t_lock;
  logic [3:0]        t_cache, t_qos, t_region;
  logic [USER_W-1:0] t_user;
  logic [2:0]        t_snoop;
  logic [SB-1:0]     t_strb;
  logic              t_stash, t_trace;
  // R15: constant tie-offs
  always_comb begin
    // R7: fill from defaults
    // R12: incr, single beat, full size
    t_len   = bus.present[PB_LEN]   ? bus.aw_len   : LEN_DEF;
    t_size  = bus.present[PB_SIZE]  ? bus.aw_size  : wct_bus_size(DATA_W);
    t_burst = bus.present[PB_BURST] ? bus.aw_burst : BURST_INCR;
    t_strb  = bus.present[PB_STRB]  ? bus.w_strb   : '1;
    // R13: zeros and normal lock
    t_id     = bus.present[PB_ID]     ? bus.aw_id     : '0;
    t_lock   = bus.present[PB_LOCK]   ? bus.aw_lock   : LOCK_NORMAL;
    t_cache  = bus.present[PB_CACHE]  ? bus.aw_cache  : NIB_DEF;
    t_qos    = bus.present[PB_QOS]    ? bus.aw_qos    : NIB_DEF;
    t_region = bus.present[PB_REGION] ? bus.aw_region : NIB_DEF;
    t_user   = bus.present[PB_USER]   ? bus.aw_user   : '0;
    t_snoop  = bus.present[PB_SNOOP]  ? bus.aw_snoop  : SNOOP_DEF;
    // R10: stash enable only with its property
    t_stash = STASH_PROP && bus.present[PB_STASH] && bus.aw_stash_en;
    // R9: trace port exists with its property
    t_trace = TRACE_PROP && bus.aw_trace;
  end
  // ----------------------------------------
  // Transfer sequencing and labelling
  // ----------------------------------------
  logic          line_hit;
  logic          all_on;
  always_comb begin
    next_s      = s;
    next_s.aw_v = 1'b0;
    next_s.bv   = 1'b0;
    next_s.done = 1'b0;
    all_on      = s.ones && (t_strb == '1);
    // Line covered: aligned, full-width incr beats filling it
    line_hit = (s.addr[LW-1:0] == '0) && (s.size == wct_bus_size(DATA_W))
            && (s.burst == BURST_INCR)
            && (9'(s.len) + 9'h001) * 9'(SB) == 9'(LINE_BYTES);
    case (s.st)
      ST_IDLE: begin
        // R6: handshake on valid and ready
        if (bus.aw_valid && s.awr) begin
          next_s.st     = ST_DATA;
          next_s.aw_v   = 1'b1;
          next_s.addr   = bus.aw_addr;
          next_s.id     = t_id;
          next_s.len    = t_len;
          next_s.size   = t_size;
          next_s.burst  = t_burst;
          next_s.lock   = t_lock;
          next_s.cache  = t_cache;
          // R8: prot is always driven
          next_s.prot   = bus.aw_prot;
          next_s.qos    = t_qos;
          next_s.region = t_region;
          next_s.user   = t_user;
          next_s.snoop  = t_snoop;
          next_s.stash  = t_stash;
          next_s.trace  = t_trace;
          next_s.beats  = 9'h000;
          next_s.ones   = 1'b1;
        end
      end
      ST_DATA: begin
        if (bus.w_valid && s.wr) begin
          next_s.bv    = 1'b1;
          next_s.data  = bus.w_data;
          next_s.strb  = t_strb;
          // R8: last comes from the source
          next_s.last  = bus.w_last;
          next_s.ones  = all_on;
          next_s.beats = s.beats + 9'h001;
          if (bus.w_last) begin
            next_s.st   = ST_DONE;
            next_s.done = 1'b1;
            // R5: fullness from address phase and strobes, not the snoop label
            // R1: whole line with all strobes is full
            // R2: anything else is partial
            // R3: a partial-labelled write may still be full
            next_s.full = line_hit && all_on;
            // R14: kind reported without variant
            case (s.snoop)
              SN_UNIQUE: next_s.kind = WK_UNIQUE;
              SN_BACK:   next_s.kind = WK_BACK;
              SN_CLEAN:  next_s.kind = WK_CLEAN;
              SN_EVICT:  next_s.kind = WK_EVICT;
              default:   next_s.kind = WK_OTHER;
            endcase
            // R4: evict has no partial form
            next_s.everr = (s.snoop == SN_EVICT) && !(line_hit && all_on);
          end
        end
      end
      ST_DONE: next_s.st = ST_IDLE;
      default: next_s.st = ST_IDLE;
    endcase
    // Ready from flops; slave waits for address before data
    next_s.awr = (next_s.st == ST_IDLE);
    next_s.wr  = (next_s.st == ST_DATA);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // R6: ready always driven
  assign bus.aw_ready   = s.awr;
  assign bus.w_ready    = s.wr;
  assign out_aw_valid   = s.aw_v;
  assign out_addr       = s.addr;
  assign out_id         = s.id;
  assign out_len        = s.len;
  assign out_size       = s.size;
  assign out_burst      = s.burst;
  assign out_lock       = s.lock;
  assign out_cache      = s.cache;
  assign out_prot       = s.prot;
  assign out_qos        = s.qos;
  assign out_region     = s.region;
  assign out_user       = s.user;
  assign out_stash_en   = s.stash;
  assign out_trace      = s.trace;
  assign out_beat_valid = s.bv;
  assign out_data       = s.data;
  assign out_strb       = s.strb;
  assign out_last       = s.last;
  assign out_done       = s.done;
  assign out_kind       = s.kind;
  assign out_full       = s.full;
  assign out_evict_err  = s.everr;
endmodule

// ==== verilog/wct_wr_master.sv ====
`timescale 1ns/1ns
module wct_wr_master
  import wct_pkg::*;
#(
  // Stash and trace off by default, matching their properties
  parameter logic [PB_N-1:0] PRESENT    = {2'b00, {(PB_N-2){1'b1}}},
  parameter bit              TRACE_PROP = 1'b0,
  parameter bit              STASH_PROP = 1'b0
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  wct_wr_if.mst            bus,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [31:0] s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp
);
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // Conditional and optional-conditional pins versus properties
  if ((TRACE_PROP != PRESENT[PB_TRACE]) ||
      (PRESENT[PB_STASH] && !STASH_PROP)) begin : g_chk
    $error("presence mask disagrees with interface properties");
  end
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic        awr, wr, arr, bv, rv;
    logic        awg, wg;
    logic [4:0]  wa;
    logic [31:0] wd;
    logic [1:0]  bresp;
    logic [31:0] rd;
    logic [1:0]  rresp;
    logic [31:0] addr, attr, data, strb;
    logic        busy, done;
    logic        awv, wv, wl;
    logic [7:0]  beat;
  } wct_ms_t;
  wct_ms_t s, next_s;
  logic [4:0] ra;
  logic       ok_w, ok_r;
  always_comb begin
    next_s = s;
    ra     = s_axi_araddr[4:0];
    ok_w   = (s.wa <= REG_CTRL) && (s.wa[1:0] == 2'h0);
    ok_r   = (ra <= REG_STAT) && (ra[1:0] == 2'h0);
    // ----------------------------------------
    // Register slave
    // ----------------------------------------
    if (s_axi_awvalid && s.awr) begin
      next_s.awg = 1'b1;
      next_s.wa  = s_axi_awaddr[4:0];
    end
    if (s_axi_wvalid && s.wr) begin
      next_s.wg = 1'b1;
      next_s.wd = s_axi_wdata;
    end
    if (s.bv && s_axi_bready) begin
      next_s.bv = 1'b0;
    end
    if (s.awg && s.wg && !s.bv) begin
      next_s.awg   = 1'b0;
      next_s.wg    = 1'b0;
      next_s.bv    = 1'b1;
      next_s.bresp = ok_w ? RESP_OKAY : RESP_SLVERR;
      // Byte enables ignored: registers are written whole
      case (s.wa)
        REG_ADDR: next_s.addr = s.wd;
        REG_ATTR: next_s.attr = s.wd;
        REG_DATA: next_s.data = s.wd;
        REG_STRB: next_s.strb = s.wd;
        REG_CTRL: begin
          // Go is dropped while a burst is in flight
          if (s.wd[0] && !s.busy) begin
            next_s.busy = 1'b1;
            next_s.done = 1'b0;
            next_s.awv  = 1'b1;
            next_s.wv   = 1'b1;
            next_s.beat = 8'h00;
            next_s.wl   = (s.attr[AT_LEN +: 8] == 8'h00);
          end
        end
        default: next_s.bresp = RESP_SLVERR;
      endcase
    end
    if (s.rv && s_axi_rready) begin
      next_s.rv = 1'b0;
    end
    if (s_axi_arvalid && s.arr) begin
      next_s.rv    = 1'b1;
      next_s.rresp = ok_r ? RESP_OKAY : RESP_SLVERR;
      case (ra)
        REG_ADDR: next_s.rd = s.addr;
        REG_ATTR: next_s.rd = s.attr;
        REG_DATA: next_s.rd = s.data;
        REG_STRB: next_s.rd = s.strb;
        REG_STAT: next_s.rd = {30'h0000_0000, s.done, s.busy};
        default:  next_s.rd = 32'h0000_0000;
      endcase
    end
    // ----------------------------------------
    // Link side
    // ----------------------------------------
    if (s.awv && bus.aw_ready) begin
      next_s.awv = 1'b0;
    end
    if (s.wv && bus.w_ready) begin
      next_s.beat = s.beat + 8'h01;
      next_s.wl   = (s.beat + 8'h01 == s.attr[AT_LEN +: 8]);
      if (s.wl) begin
        next_s.wv   = 1'b0;
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
    end
    next_s.awr = !next_s.awg && !next_s.bv;
    next_s.wr  = !next_s.wg && !next_s.bv;
    next_s.arr = !next_s.rv;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready   = s.awr;
  assign s_axi_wready    = s.wr;
  assign s_axi_bvalid    = s.bv;
  assign s_axi_bresp     = s.bresp;
  assign s_axi_arready   = s.arr;
  assign s_axi_rvalid    = s.rv;
  assign s_axi_rdata     = s.rd;
  assign s_axi_rresp     = s.rresp;
  // R11: no master-only pins in this set
  assign bus.present     = PRESENT;
  assign bus.aw_valid    = s.awv;
  assign bus.aw_addr     = s.addr;
  assign bus.aw_id       = s.attr[AT_ID +: ID_W];
  assign bus.aw_region   = NIB_DEF;
  assign bus.aw_len      = s.attr[AT_LEN +: 8];
  assign bus.aw_size     = s.attr[AT_SIZE +: 3];
  assign bus.aw_burst    = s.attr[AT_BURST +: 2];
  assign bus.aw_lock     = LOCK_NORMAL;
  assign bus.aw_cache    = NIB_DEF;
  // R8: protection always driven
  assign bus.aw_prot     = 3'h0;
  assign bus.aw_qos      = NIB_DEF;
  assign bus.aw_user     = '0;
  assign bus.aw_snoop    = s.attr[AT_SNOOP +: 3];
  assign bus.aw_stash_en = 1'b0;
  assign bus.aw_trace    = 1'b0;
  // Beat data counts up from the base so beats are told apart
  assign bus.w_valid     = s.wv;
  assign bus.w_data      = s.data + {24'h00_0000, s.beat};
  assign bus.w_strb      = s.strb[DATA_W/8-1:0];
  assign bus.w_last      = s.wl;
endmodule

// ==== bench/wct_link_checker.sv ====
`timescale 1ns/1ns
module wct_link_checker
  import wct_pkg::*;
#(
  parameter logic [PB_N-1:0] PRESENT = '1
) (
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire logic                aw_valid,
  input wire logic                aw_ready,
  input wire logic [ADDR_W-1:0]   aw_addr,
  input wire logic [7:0]          aw_len,
  input wire logic [PB_N-1:0]     present,
  input wire logic                w_valid,
  input wire logic                w_ready,
  input wire logic [DATA_W-1:0]   w_data,
  input wire logic [DATA_W/8-1:0] w_strb,
  input wire logic                w_last
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Beat count of the burst under way
  // ----------------------------------------
  logic [7:0] len_q;
  logic [7:0] beats;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      len_q <= 8'h00;
      beats <= 8'h00;
    end else if (aw_valid && aw_ready) begin
      len_q <= aw_len;
      beats <= 8'h00;
    end else if (w_valid && w_ready) begin
      beats <= beats + 8'h01;
    end
  end
  // ----------------------------------------
  // Link handshakes
  // ----------------------------------------
  chk_aw_drop: assert property (
    aw_valid && aw_ready |=> !aw_valid) else $error("aw valid kept");
  chk_w_held: assert property (
    w_valid && !w_ready |=> w_valid && $stable(w_data) && $stable(w_strb)
      && $stable(w_last)) else $error("w beat changed while waiting");
  chk_w_after_aw: assert property (
    $rose(w_ready) |-> $past(aw_valid && aw_ready))
    else $error("w ready without address");
  chk_one_burst: assert property (
    w_ready |-> !aw_ready) else $error("address open during burst");
  chk_wready_ends: assert property (
    w_valid && w_ready && w_last |=> !w_ready) else $error("w ready kept");
  chk_aw_reopen: assert property (
    w_valid && w_ready && w_last |-> ##2 aw_ready)
    else $error("address not reopened");
  chk_last_count: assert property (
    w_valid && w_ready |-> w_last == (beats == len_q))
    else $error("last flag off count");
  chk_mask_fixed: assert property (
    aw_valid |-> present == PRESENT) else $error("presence mask wrong");
  cover property (aw_valid && aw_ready && aw_len == 8'h0f
                  && aw_addr[5:0] == 6'h00);
  cover property (w_valid && !w_ready);
  cover property (w_valid && w_ready && w_last);
endmodule

// ==== bench/test_write_channel_signal_tieoff.sv ====
`timescale 1ns/1ns
module test_write_channel_signal_tieoff
  import wct_pkg::*;
;
  // Only len, snoop, strobes present: the rest must be tied off
  localparam logic [PB_N-1:0] PRES = 13'h0604;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic              s_axi_arvalid = 1'b0;
  logic              s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [31:0]       s_axi_awaddr = '0, s_axi_wdata = '0;
  logic [31:0]       s_axi_araddr = '0;
  logic [3:0]        s_axi_wstrb = 4'hf;
  logic              s_axi_awready, s_axi_wready, s_axi_arready;
  logic              s_axi_bvalid, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [31:0]       s_axi_rdata;
  logic              out_aw_valid, out_beat_valid, out_last, out_done;
  logic              out_lock, out_stash_en, out_trace, out_full;
  logic              out_evict_err;
  logic [ADDR_W-1:0] out_addr;
  logic [DATA_W-1:0] out_data;
  logic [ID_W-1:0]   out_id;
  logic [USER_W-1:0] out_user;
  logic [7:0]        out_len;
  logic [3:0]        out_cache, out_qos, out_region, out_strb;
  logic [2:0]        out_size, out_prot;
  logic [1:0]        out_burst;
  wct_kind_t         out_kind;
  logic [31:0]       seed = 32'h0000_0028, e_addr, e_base;
  logic [3:0]        e_strb;
  logic [2:0]        codes [5] = '{SN_UNIQUE, SN_CLEAN, SN_BACK,
                                   SN_EVICT, 3'h5};
  int                e_len, beats, n_tests, bad_count;
  always #2 aclk = ~aclk;
  wct_wr_if lnk ();
  wct_wr_master #(.PRESENT(PRES)) u_wct_wr_master (.*, .bus(lnk));
  wct_wr_slave u_wct_wr_slave (.*, .bus(lnk));
  wct_link_checker #(.PRESENT(PRES)) u_wct_link_checker (
    .aclk, .aresetn, .aw_valid(lnk.aw_valid), .aw_ready(lnk.aw_ready),
    .aw_addr(lnk.aw_addr), .aw_len(lnk.aw_len), .present(lnk.present),
    .w_valid(lnk.w_valid), .w_ready(lnk.w_ready), .w_data(lnk.w_data),
    .w_strb(lnk.w_strb), .w_last(lnk.w_last));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic wct_kind_t kind_of(input logic [2:0] sn);
    case (sn)
      SN_UNIQUE: return WK_UNIQUE;
      SN_CLEAN:  return WK_CLEAN;
      SN_BACK:   return WK_BACK;
      SN_EVICT:  return WK_EVICT;
      default:   return WK_OTHER;
    endcase
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tmo();
    chk("handshake", 1, 0);
    finish_test();
  endtask
  // Bready and rready stay high, so each answer is taken when seen
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    bit aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    for (int n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        return;
      end
      if (s_axi_awready && !aw) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    tmo();
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] e,
                      input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (s_axi_rvalid) begin
        chk("rdata", e, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
        return;
      end
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    tmo();
  endtask
  // ----------------------------------------
  // Link monitor
  // ----------------------------------------
  always @(posedge aclk) begin
    if (aresetn && out_aw_valid) begin
      chk("addr", e_addr, out_addr);
      chk("len", e_len, out_len);
      chk("size", 3'h2, out_size);
      chk("burst", 2'h1, out_burst);
      chk("zeros", 0, {out_id, out_region, out_lock, out_cache, out_qos,
                       out_user, out_stash_en, out_trace});
    end
    if (aresetn && out_beat_valid) begin
      chk("data", e_base + beats, out_data);
      chk("strb", e_strb, out_strb);
      chk("last", beats == e_len, out_last);
      beats++;
    end
  end
  task automatic burst(input logic [31:0] a, input int len,
                       input logic [2:0] sn, input logic [3:0] st);
    logic [1:0]  r;
    logic [31:0] at;
    bit          full;
    bit          seen;
    e_addr = a;
    e_len = len;
    e_strb = st;
    e_base = rnd();
    beats = 0;
    seen = 0;
    at = rnd();
    at[7:0] = len[7:0];
    at[15:13] = sn;
    full = a[5:0] == 6'h00 && len == 15 && st == 4'hf;
    wr(REG_ADDR, a, r);
    wr(REG_ATTR, at, r);
    wr(REG_DATA, e_base, r);
    wr(REG_STRB, {28'h000_0000, st}, r);
    rchk(REG_ATTR, at, RESP_OKAY);
    rchk(REG_DATA, e_base, RESP_OKAY);
    wr(REG_CTRL, 32'h0000_0001, r);
    chk("go_resp", RESP_OKAY, r);
    for (int n = 0; n < 200 && !seen; n++) begin
      @(posedge aclk);
      seen = out_done;
    end
    if (!seen) tmo();
    @(posedge aclk);
    chk("beats", len + 1, beats);
    chk("kind", kind_of(sn), out_kind);
    chk("full", full, out_full);
    chk("evict_err", sn == SN_EVICT && !full, out_evict_err);
    $display("burst done snoop %0d full %0d", sn, full);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [1:0] r;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rchk(REG_ADDR, 0, RESP_OKAY);
    rchk(REG_STAT, 0, RESP_OKAY);
    rchk(REG_CTRL, 0, RESP_OKAY);
    rchk(32'h0000_0018, 0, RESP_SLVERR);
    wr(32'h0000_001c, 32'h0000_0005, r);
    chk("bad_wr", RESP_SLVERR, r);
    $display("register checks done");
    for (int i = 0; i < 10; i++) begin
      if (i < 5) burst(rnd() & 32'hffff_ffc0, 15, codes[i], 4'hf);
      else if (i % 3 == 0)
        burst((rnd() & 32'hffff_ffc0) | 8, 15, codes[i % 5], 4'hf);
      else if (i % 3 == 1)
        burst(rnd() & 32'hffff_ffc0, rnd() % 15, codes[i % 5], 4'hf);
      else burst(rnd() & 32'hffff_ffc0, 15, codes[i % 5], 4'h7);
    end
    rchk(REG_STAT, 32'h0000_0002, RESP_OKAY);
    finish_test();
  end
endmodule
